// ===== hdl/ats_pkg.sv
package ats_pkg;

  // --------------------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int STROBE_WIDTH_US = 190;
  localparam int ZC_WIDTH_US = 100;
  localparam int STROBE_CYCLES = STROBE_WIDTH_US * 1000 / CLK_PERIOD_NS;
  localparam int ZC_CYCLES = ZC_WIDTH_US * 1000 / CLK_PERIOD_NS;
  localparam int STATUS_PERIOD_S = 3;
  localparam int STATUS_SHOW_S = 1;
  localparam int STATUS_PERIOD_CYCLES = STATUS_PERIOD_S * CLK_HZ;
  localparam int STATUS_SHOW_CYCLES = STATUS_SHOW_S * CLK_HZ;

  // --------------------------------------------------------------------------
  // frequency limits, millihertz
  // --------------------------------------------------------------------------
  localparam int FW = 24;
  localparam logic [FW-1:0] RANGE_RESET_MHZ = 24'h002710;
  localparam logic [FW-1:0] SYNC_MIN_MHZ = 24'h003A98;
  localparam logic [FW-1:0] SYNC_MAX_MHZ = 24'h124F80;
  localparam logic [15:0] SPEED_RESET = 16'h0001;

  // displayed status field
  typedef enum logic [1:0] {
    ATS_SHOW_NORMAL,
    ATS_SHOW_SYNCED,
    ATS_SHOW_UNSYNCED
  } ats_show_type;

  // transient trigger states
  typedef enum logic [1:0] {
    ATS_TR_IDLE,
    ATS_TR_WAIT,
    ATS_TR_RUN
  } ats_tr_type;

endpackage : ats_pkg

// ===== hdl/ats_aux_io.sv
`timescale 1ns/1ps
// Functional notes
// R01: with trigger mode on, an armed transient starts only on trigger rising edge
// R02: waiting armed transient reports running with progress 0%
// R03: lock only to references within setpoint plus/minus range; range resets to 10Hz
// R04: generated frequency clamped to setpoint plus/minus range, even without reference
// R05: sync input accepted from 15 Hz to 1200 Hz, timed on rising edges
// R06: sync source selects mains line-to-line or TTL sync pin
// R07: PLL lock state tracked and readable as locked or unlocked
// R08: when locked, status shows synced 1 s of every 3 s
// R09: phase offset setting shifts phase A against the reference
// R10: speed setting sets PLL tracking rate; small values steadier
// R11: phases B and C keep programmed angles relative to phase A
// R12: controller sets frequency setpoint near reference before enabling sync
// R13: controller should not enable output until lock is reported
// R14: strobe pulse on transient start when its enable is set
// R15: strobe pulse on output relay change when its enable is set
// R16: strobe pulse on voltage, frequency, waveform or angle change when enabled
// R17: three separate enables for the three strobe sources
// R18: strobe pulse lasts 190 us
// R19: phase sync output pulses about 100 us at each phase A zero crossing
// R20: trigger and sync pins pass a two-stage synchroniser before edge detection
// R21: pulse widths are counted; new events do not truncate an active pulse
module ats_aux_io
  import ats_pkg::*;
#(
  parameter int STROBE_LEN = STROBE_CYCLES,
  parameter int ZC_LEN = ZC_CYCLES,
  parameter int STAT_PERIOD = STATUS_PERIOD_CYCLES,
  parameter int STAT_SHOW = STATUS_SHOW_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins
  input wire logic transient_trigger_in,
  input wire logic sync_ttl_in,
  input wire logic mains_ll_zc_in,
  output logic event_strobe_out,
  output logic phase_sync_out,
  // transient control
  input wire logic trig_mode_en,
  input wire logic transient_arm,
  input wire logic transient_done,
  output logic transient_running,
  output logic transient_started,
  output logic [6:0] transient_progress_gate,
  // sync configuration
  input wire logic sync_en,
  input wire logic sync_src_ttl,
  input wire logic [FW-1:0] freq_setpoint,
  input wire logic [FW-1:0] sync_range,
  input wire logic sync_range_wr,
  input wire logic [15:0] ref_phase_offset_setting,
  input wire logic [15:0] sync_speed,
  input wire logic [FW-1:0] ref_period_to_mhz,
  // phase generator side
  input wire logic phase_a_zero_cross,
  input wire logic phase_sync_out_en,
  output logic [FW-1:0] gen_freq_mhz,
  output logic [15:0] phase_a_offset,
  output logic phase_a_realign,
  output logic pll_locked,
  output ats_show_type status_show,
  // strobe sources
  input wire logic strobe_on_transient_en,
  input wire logic strobe_on_relay_change_en,
  input wire logic strobe_on_param_change_en,
  input wire logic relay_state,
  input wire logic param_changed
);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] tt_s_q, ttl_s_q, ll_s_q;
  logic tt_d1_q, ref_d1_q, relay_q;

  // two flops per pin; only the second stage is read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tt_s_q <= 2'h0;
      ttl_s_q <= 2'h0;
      ll_s_q <= 2'h0;
    end else begin
      tt_s_q <= {tt_s_q[0], transient_trigger_in}; // R20
      ttl_s_q <= {ttl_s_q[0], sync_ttl_in}; // R20
      ll_s_q <= {ll_s_q[0], mains_ll_zc_in}; // R20
    end
  end

  logic ref_lvl;
  assign ref_lvl = sync_src_ttl ? ttl_s_q[1] : ll_s_q[1]; // R06

  // edge history
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tt_d1_q <= 1'b0;
      ref_d1_q <= 1'b0;
      relay_q <= 1'b0;
    end else begin
      tt_d1_q <= tt_s_q[1];
      ref_d1_q <= ref_lvl;
      relay_q <= relay_state;
    end
  end

  logic tt_rise, ref_rise, relay_chg;
  assign tt_rise = tt_s_q[1] & ~tt_d1_q;
  assign ref_rise = ref_lvl & ~ref_d1_q; // R05
  assign relay_chg = relay_state ^ relay_q;

  // --------------------------------------------------------------------------
  // transient trigger
  // --------------------------------------------------------------------------
  ats_tr_type tr_q;
  logic start_pulse;
  assign start_pulse = (tr_q == ATS_TR_WAIT && tt_rise)
                       || (tr_q == ATS_TR_IDLE && transient_arm && !trig_mode_en);

  // armed program waits for trigger edge when trigger mode is on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tr_q <= ATS_TR_IDLE;
    end else begin
      unique case (tr_q)
        ATS_TR_IDLE: begin
          if (transient_arm) begin
            tr_q <= trig_mode_en ? ATS_TR_WAIT : ATS_TR_RUN; // R01
          end
        end
        ATS_TR_WAIT: begin
          if (tt_rise) begin
            tr_q <= ATS_TR_RUN; // R01
          end
        end
        ATS_TR_RUN: begin
          if (transient_done) begin
            tr_q <= ATS_TR_IDLE;
          end
        end
      endcase
    end
  end

  assign transient_running = tr_q != ATS_TR_IDLE; // R02
  assign transient_started = tr_q == ATS_TR_RUN;
  assign transient_progress_gate = (tr_q == ATS_TR_RUN) ? 7'h64 : 7'h00; // R02

  // --------------------------------------------------------------------------
  // sync engine
  // --------------------------------------------------------------------------
  logic [FW-1:0] range_q;
  logic [FW-1:0] freq_q;
  logic lock_q;
  logic [FW-1:0] lo_lim, hi_lim;
  logic ref_ok;

  // range register, 10 Hz after reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      range_q <= RANGE_RESET_MHZ; // R03
    end else if (sync_range_wr) begin
      range_q <= sync_range;
    end
  end

  assign lo_lim = (freq_setpoint > range_q) ? freq_setpoint - range_q : '0;
  assign hi_lim = freq_setpoint + range_q;
  assign ref_ok = ref_period_to_mhz >= lo_lim && ref_period_to_mhz <= hi_lim
                  && ref_period_to_mhz >= SYNC_MIN_MHZ
                  && ref_period_to_mhz <= SYNC_MAX_MHZ; // R03 R05

  // frequency slews toward reference by speed per reference edge
  logic [FW:0] up_f, dn_f;
  assign up_f = {1'b0, freq_q} + {9'h000, sync_speed};
  assign dn_f = {1'b0, freq_q} - {9'h000, sync_speed};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_q <= '0;
      lock_q <= 1'b0;
    end else if (!sync_en) begin
      freq_q <= freq_setpoint;
      lock_q <= 1'b0;
    end else if (ref_rise) begin
      lock_q <= ref_ok && (freq_q == ref_period_to_mhz); // R07
      if (!ref_ok) begin
        freq_q <= freq_setpoint; // R04
      end else if (freq_q < ref_period_to_mhz) begin
        freq_q <= (up_f[FW-1:0] > ref_period_to_mhz) ? ref_period_to_mhz
                  : up_f[FW-1:0]; // R10
      end else if (freq_q > ref_period_to_mhz) begin
        freq_q <= (dn_f[FW-1:0] < ref_period_to_mhz || dn_f[FW])
                  ? ref_period_to_mhz : dn_f[FW-1:0]; // R10
      end
    end
  end

  // final clamp keeps output inside the window
  always_comb begin
    if (freq_q > hi_lim) begin
      gen_freq_mhz = hi_lim; // R04
    end else if (freq_q < lo_lim) begin
      gen_freq_mhz = lo_lim; // R04
    end else begin
      gen_freq_mhz = freq_q;
    end
  end

  assign pll_locked = lock_q; // R07
  assign phase_a_offset = ref_phase_offset_setting; // R09
  // only phase A realigns; B and C follow A by their own angles
  assign phase_a_realign = sync_en & lock_q & ref_rise; // R11

  // --------------------------------------------------------------------------
  // status display rotation
  // --------------------------------------------------------------------------
  logic [31:0] stat_cnt_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_cnt_q <= '0;
    end else if (!lock_q || stat_cnt_q == 32'(STAT_PERIOD - 1)) begin
      stat_cnt_q <= '0;
    end else begin
      stat_cnt_q <= stat_cnt_q + 32'h1;
    end
  end

  always_comb begin
    if (!sync_en) begin
      status_show = ATS_SHOW_NORMAL;
    end else if (!lock_q) begin
      status_show = ATS_SHOW_UNSYNCED;
    end else if (stat_cnt_q < 32'(STAT_SHOW)) begin
      status_show = ATS_SHOW_SYNCED; // R08
    end else begin
      status_show = ATS_SHOW_NORMAL; // R08
    end
  end

  // --------------------------------------------------------------------------
  // output pulses
  // --------------------------------------------------------------------------
  logic strobe_evt;
  logic [31:0] stb_cnt_q, zc_cnt_q;
  assign strobe_evt = (strobe_on_transient_en && start_pulse) // R14 R17
                      || (strobe_on_relay_change_en && relay_chg) // R15 R17
                      || (strobe_on_param_change_en && param_changed); // R16 R17

  // strobe width counter; events during a pulse are absorbed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stb_cnt_q <= '0;
    end else if (stb_cnt_q != 32'h0) begin
      stb_cnt_q <= stb_cnt_q - 32'h1; // R21
    end else if (strobe_evt) begin
      stb_cnt_q <= 32'(STROBE_LEN); // R18
    end
  end

  // zero-cross width counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zc_cnt_q <= '0;
    end else if (zc_cnt_q != 32'h0) begin
      zc_cnt_q <= zc_cnt_q - 32'h1; // R21
    end else if (phase_sync_out_en && phase_a_zero_cross) begin
      zc_cnt_q <= 32'(ZC_LEN); // R19
    end
  end

  // registered pulse outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      event_strobe_out <= 1'b0;
      phase_sync_out <= 1'b0;
    end else begin
      event_strobe_out <= stb_cnt_q != 32'h0;
      phase_sync_out <= zc_cnt_q != 32'h0;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  sequence strobe_fire_s;
    strobe_evt && stb_cnt_q == 32'h0;
  endsequence

  strobe_start_a: assert property (@(posedge clk) disable iff (!rst_b) // R18
    strobe_fire_s |=> ##1 event_strobe_out)
    else $error("strobe did not start");

  strobe_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // R21
    $fell(event_strobe_out) |-> $past(stb_cnt_q, 2) == 32'h1)
    else $error("strobe ended early");

  zc_pulse_a: assert property (@(posedge clk) disable iff (!rst_b) // R19
    phase_sync_out_en && phase_a_zero_cross && zc_cnt_q == 32'h0 |=> ##1 phase_sync_out)
    else $error("zero cross pulse missing");

  trig_wait_a: assert property (@(posedge clk) disable iff (!rst_b) // R01
    tr_q == ATS_TR_WAIT && !tt_rise |=> tr_q == ATS_TR_WAIT)
    else $error("transient started without trigger");

  progress_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // R02
    tr_q == ATS_TR_WAIT |-> transient_running && transient_progress_gate == 7'h00)
    else $error("waiting transient shows progress");

  freq_clamp_a: assert property (@(posedge clk) disable iff (!rst_b) // R04
    gen_freq_mhz <= hi_lim && gen_freq_mhz >= lo_lim)
    else $error("frequency outside window");

  lock_window_a: assert property (@(posedge clk) disable iff (!rst_b) // R03
    $rose(lock_q) |-> $past(ref_ok))
    else $error("locked outside range");

  status_sync_a: assert property (@(posedge clk) disable iff (!rst_b) // R08
    sync_en && !lock_q |-> status_show == ATS_SHOW_UNSYNCED)
    else $error("unlocked status wrong");

  relay_strobe_a: assert property (@(posedge clk) disable iff (!rst_b) // R15
    strobe_on_relay_change_en && relay_chg && stb_cnt_q == 32'h0 |=> stb_cnt_q != 32'h0)
    else $error("relay change strobe missing");

endmodule : ats_aux_io

// ===== verif/ats_ext_equip.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// bench equipment driving the trigger and reference pins
// ------------------------------------------------------------------
module ats_ext_equip (
  // clock
  input wire logic clk,
  // pins
  output logic trig_pin,
  output logic ttl_pin,
  output logic mains_pin
);
  // pins idle low while no edge is sent
  initial begin
    trig_pin = 1'b0;
    ttl_pin = 1'b0;
    mains_pin = 1'b0;
  end
  // one rising edge, a full cycle wide so the synchroniser cannot miss it
  task trig_edge;
    @(negedge clk);
    trig_pin = 1'b1;
    @(negedge clk);
    trig_pin = 1'b0;
  endtask : trig_edge
  // n reference periods on the chosen source; only rising edges carry timing
  task ref_pulses(input bit ttl, input int n);
    repeat (n) begin
      @(negedge clk);
      if (ttl) ttl_pin = 1'b1;
      else mains_pin = 1'b1;
      repeat (6) @(negedge clk);
      ttl_pin = 1'b0;
      mains_pin = 1'b0;
      repeat (6) @(negedge clk);
    end
  endtask : ref_pulses
endmodule : ats_ext_equip

// ===== verif/aux_trigger_sync_io_bench.sv
`timescale 1ns/1ps
module aux_trigger_sync_io_bench;
  import ats_pkg::*;
  logic clk, rst_b, tt_pin, ttl_pin, mains_pin, strobe, zc_out, trig_mode, arm, done;
  logic running, started, sync_en, src_ttl, rng_wr, zc_in, zc_en, locked, realign;
  logic tr_en, rl_en, pc_en, relay, pchg;
  logic [6:0] gate;
  logic [FW-1:0] setpt, rng, ref_f, gen_f;
  logic [15:0] ph_set, speed, ph_off;
  ats_show_type show;
  int err_total, checks, w, n, re_cnt;
  // ------------------------------------------------------------------
  // clock, parts and helpers
  // ------------------------------------------------------------------
  always #2.5 clk = ~clk;
  // counts phase A realign pulses, one per locked reference edge
  always @(negedge clk) if (realign === 1'b1) re_cnt++;
  ats_ext_equip ats_ext_equip_i (.clk(clk), .trig_pin(tt_pin), .ttl_pin(ttl_pin),
    .mains_pin(mains_pin));
  ats_aux_io #(.STROBE_LEN(20), .ZC_LEN(10), .STAT_PERIOD(30), .STAT_SHOW(10)) ats_aux_io_i (
    .clk(clk), .rst_b(rst_b), .transient_trigger_in(tt_pin), .sync_ttl_in(ttl_pin),
    .mains_ll_zc_in(mains_pin), .event_strobe_out(strobe), .phase_sync_out(zc_out),
    .trig_mode_en(trig_mode), .transient_arm(arm), .transient_done(done),
    .transient_running(running), .transient_started(started),
    .transient_progress_gate(gate), .sync_en(sync_en), .sync_src_ttl(src_ttl),
    .freq_setpoint(setpt), .sync_range(rng), .sync_range_wr(rng_wr),
    .ref_phase_offset_setting(ph_set), .sync_speed(speed), .ref_period_to_mhz(ref_f),
    .phase_a_zero_cross(zc_in), .phase_sync_out_en(zc_en), .gen_freq_mhz(gen_f),
    .phase_a_offset(ph_off), .phase_a_realign(realign), .pll_locked(locked),
    .status_show(show), .strobe_on_transient_en(tr_en), .strobe_on_relay_change_en(rl_en),
    .strobe_on_param_change_en(pc_en), .relay_state(relay), .param_changed(pchg));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // waits a bounded time for a pulse, then counts its width in cycles
  task measure(input bit zc, output int wd);
    n = 0;
    wd = 0;
    while (n < 40 && (zc ? zc_out : strobe) !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    while ((zc ? zc_out : strobe) === 1'b1 && wd < 200) begin
      @(negedge clk);
      wd++;
    end
  endtask : measure
  task stop_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task test_trigger;
    trig_mode = 1'b1;
    tr_en = 1'b1;
    arm = 1'b1;
    @(negedge clk);
    arm = 1'b0;
    repeat (20) @(negedge clk);
    chk({running, started, gate}, {2'b10, 7'h00});
    chk(strobe, 1'b0);
    ats_ext_equip_i.trig_edge();
    n = 0;
    while (started !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk({started, gate}, {1'b1, 7'h64});
    measure(1'b0, w);
    chk(w, 20);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    tr_en = 1'b0;
    @(negedge clk);
    chk(running, 1'b0);
  endtask : test_trigger
  task test_strobe;
    pc_en = 1'b1;
    pchg = 1'b1;
    @(negedge clk);
    pchg = 1'b0;
    repeat (8) @(negedge clk);
    pchg = 1'b1;
    @(negedge clk);
    pchg = 1'b0;
    measure(1'b0, w);
    chk(w, 20 - 8);
    pc_en = 1'b0;
    relay = 1'b1;
    measure(1'b0, w);
    chk(w, 0);
    rl_en = 1'b1;
    relay = 1'b0;
    measure(1'b0, w);
    chk(w, 20);
  endtask : test_strobe
  task test_zc;
    zc_in = 1'b1;
    @(negedge clk);
    zc_in = 1'b0;
    measure(1'b1, w);
    chk(w, 0);
    zc_en = 1'b1;
    zc_in = 1'b1;
    @(negedge clk);
    zc_in = 1'b0;
    measure(1'b1, w);
    chk(w, 10);
  endtask : test_zc
  task test_sync;
    setpt = 24'h00C350;
    ref_f = 24'h00EE48;
    sync_en = 1'b1;
    ats_ext_equip_i.ref_pulses(1'b0, 3);
    chk({locked, show, gen_f}, {1'b0, ATS_SHOW_UNSYNCED, 24'h00C350});
    ref_f = 24'h00C350;
    ats_ext_equip_i.ref_pulses(1'b0, 2);
    chk(locked, 1'b1);
    chk(gen_f, 24'h00C350);
    chk(ph_off, 16'h1234);
    w = 0;
    repeat (30) begin
      @(negedge clk);
      if (show === ATS_SHOW_SYNCED) w++;
    end
    chk(w, 10);
    // output relay closed only once lock is reported
    relay = 1'b1;
    measure(1'b0, w);
    chk(w, 20);
    rng = 24'h007530;
    rng_wr = 1'b1;
    speed = 16'h03E8;
    ref_f = 24'h00D6D8;
    @(negedge clk);
    rng_wr = 1'b0;
    src_ttl = 1'b1;
    ats_ext_equip_i.ref_pulses(1'b1, 2);
    chk(locked, 1'b0);
    w = re_cnt;
    ats_ext_equip_i.ref_pulses(1'b1, 6);
    chk({locked, gen_f}, {1'b1, 24'h00D6D8});
    chk(re_cnt - w, 2);
    setpt = 24'h002EE0;
    ref_f = 24'h002EE0;
    ats_ext_equip_i.ref_pulses(1'b1, 3);
    chk(locked, 1'b0);
  endtask : test_sync
  // main sequence; inputs change on falling edges only
  initial begin
    {clk, rst_b, trig_mode, arm, done, sync_en, src_ttl, rng_wr, zc_in, zc_en} = '0;
    {tr_en, rl_en, pc_en, relay, pchg, setpt, rng, ref_f} = '0;
    ph_set = 16'h1234;
    speed = 16'h0001;
    err_total = 0;
    checks = 0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    test_trigger();
    test_strobe();
    test_zc();
    test_sync();
    stop_test();
  end
  // cuts a hang short
  initial begin
    #100000;
    err_total++;
    stop_test();
  end
endmodule : aux_trigger_sync_io_bench
